// >>> core/psar_regs.sv
// phy status, identifier, advertisement and partner ability registers
`timescale 1ns/1ps
module psar_regs #(
  parameter logic [15:0] OUI_HIGH = 16'h1234, // arbitrary value
  parameter logic [5:0] OUI_LOW = 6'h15, // arbitrary value
  parameter logic [5:0] MODEL_NUM = 6'h0a, // arbitrary value
  parameter logic [3:0] REV_NUM = 4'h1 // arbitrary value
) (
  input wire logic ref_clk, // 25 MHz clock
  input wire logic resetn, // async reset, active low
  input wire psar_pkg::psar_req_t req, // indexed management request
  input wire psar_pkg::psar_cond_t cond, // line conditions from phy core
  input wire logic partner_valid, // one-cycle strobe: partner word received
  input wire logic [15:0] partner_word, // partner's base page
  input wire logic speed_sel_pin, // speed strap pin
  output logic [15:0] rd_data_q, // read data
  output logic rd_valid_q, // one-cycle pulse: read data valid
  output logic [15:0] advert_q, // local advertisement to the autoneg engine
  output logic [15:0] partner_q // partner ability register
);

  // ****************************************
  // request decode
  // ****************************************
  logic rd_status;
  logic wr_advert;
  logic strap_sync;
  logic strap_done_q;
  logic [1:0] strap_cnt_q;
  logic rfault_q;
  logic link_q;
  logic jabber_q;
  logic an_done_q;
  logic [15:0] status_word;
  logic [15:0] ident_low_word;
  logic [15:0] rd_mux;
  logic [4:0] rd_idx_q;

  // registers exist only behind the index port, no memory map
  assign rd_status = req.rd && (req.idx == psar_pkg::IDX_STATUS);
  assign wr_advert = req.wr && (req.idx == psar_pkg::IDX_ADVERT);

  // ****************************************
  // speed strap capture
  // ****************************************
  psar_sync #(
    .WIDTH(1)
  ) u_strap_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .async_in(speed_sel_pin),
    .sync_q(strap_sync)
  );

  // wait for the synchroniser to fill before trusting the strap
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      strap_cnt_q <= '0;
      strap_done_q <= 1'b0;
    end
    else if (!strap_done_q)
    begin
      if (strap_cnt_q == psar_pkg::STRAP_SETTLE)
        strap_done_q <= 1'b1;
      else
        strap_cnt_q <= strap_cnt_q + 2'h1;
    end
  end

  // ****************************************
  // status latches and autoneg complete register
  // ****************************************
  // a new event in the read cycle wins over the release
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      rfault_q <= 1'b0;
    else
      rfault_q <= (rfault_q && !rd_status) || cond.remote_fault;
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      jabber_q <= 1'b0;
    else
      jabber_q <= (jabber_q && !rd_status) || cond.jabber;
  end

  // link stays low after a drop until read, then follows the line again
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      link_q <= 1'b0;
    else if (rd_status)
      link_q <= cond.link_up;
    else
      link_q <= link_q && cond.link_up;
  end

  // a link that comes up from reset with no read still shows down: intended
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      an_done_q <= 1'b0;
    else
      an_done_q <= cond.an_done;
  end

  always_comb
  begin
    status_word = '0;
    status_word[psar_pkg::ST_T4] = 1'b0;
    status_word[psar_pkg::ST_CAP_HI:psar_pkg::ST_CAP_LO] = psar_pkg::ST_CAPS;
    status_word[psar_pkg::ST_AN_DONE] = an_done_q;
    status_word[psar_pkg::ST_RFAULT] = rfault_q;
    status_word[psar_pkg::ST_AN_ABLE] = 1'b1;
    status_word[psar_pkg::ST_LINK] = link_q;
    status_word[psar_pkg::ST_JABBER] = jabber_q;
    status_word[psar_pkg::ST_EXT_CAP] = 1'b1;
  end

  assign ident_low_word = {OUI_LOW, MODEL_NUM, REV_NUM};

  // ****************************************
  // advertisement register
  // ****************************************
  // next page and t4 stay writable; the engine never uses them
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      advert_q <= psar_pkg::ADVERT_RESET;
    else if (!strap_done_q && (strap_cnt_q == psar_pkg::STRAP_SETTLE))
    begin
      advert_q[psar_pkg::AD_TX_FD] <= strap_sync;
      advert_q[psar_pkg::AD_10_FD] <= strap_sync;
      advert_q[psar_pkg::AD_10_HD] <= strap_sync;
    end
    else if (wr_advert)
      advert_q <= req.wdata & psar_pkg::ADVERT_WMASK;
  end

  // ****************************************
  // partner ability register
  // ****************************************
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      partner_q <= psar_pkg::PARTNER_RESET;
    else if (partner_valid)
      partner_q <= partner_word & psar_pkg::PARTNER_MASK;
  end

  // ****************************************
  // read port
  // ****************************************
  always_comb
  begin
    case (req.idx)
      psar_pkg::IDX_STATUS: rd_mux = status_word;
      psar_pkg::IDX_IDENT_HIGH: rd_mux = OUI_HIGH;
      psar_pkg::IDX_IDENT_LOW: rd_mux = ident_low_word;
      psar_pkg::IDX_ADVERT: rd_mux = advert_q;
      psar_pkg::IDX_PARTNER: rd_mux = partner_q;
      default: rd_mux = '0;
    endcase
  end

  // status data is taken before the latches release in the same edge
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_data_q <= '0;
      rd_valid_q <= 1'b0;
      rd_idx_q <= '0;
    end
    else
    begin
      rd_valid_q <= req.rd;
      rd_idx_q <= req.idx;
      if (req.rd)
        rd_data_q <= rd_mux;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  sequence seq_status_rd;
    rd_status;
  endsequence

  sequence seq_data_out(logic [4:0] idx);
    rd_valid_q && (rd_idx_q == idx);
  endsequence

  sequence seq_partner_in;
    partner_valid;
  endsequence

  AST_STATUS_CONST: assert property (
    seq_status_rd |=> seq_data_out(psar_pkg::IDX_STATUS) ##0
    (rd_data_q[psar_pkg::ST_CAP_HI:psar_pkg::ST_CAP_LO] == psar_pkg::ST_CAPS) &&
    !rd_data_q[psar_pkg::ST_T4] && rd_data_q[psar_pkg::ST_AN_ABLE] &&
    rd_data_q[psar_pkg::ST_EXT_CAP] && (rd_data_q[10:6] == 5'h00))
    else $error("status constant bits wrong");

  AST_AN_DONE: assert property (seq_status_rd |=>
    (rd_data_q[psar_pkg::ST_AN_DONE] == $past(an_done_q)))
    else $error("autoneg complete bit not reported");

  AST_RFAULT_HOLD: assert property (cond.remote_fault ##1 (!rd_status)[*2] |=> rfault_q)
    else $error("remote fault latch released without read");

  AST_LINK_LOW: assert property ((!cond.link_up && !rd_status) ##1 !rd_status |=> !link_q)
    else $error("link latch did not stay low");

  AST_JABBER_RELEASE: assert property ((rd_status && !cond.jabber) |=> !jabber_q)
    else $error("jabber latch not released by read");

  AST_JABBER_READ: assert property (jabber_q && rd_status |=> rd_data_q[psar_pkg::ST_JABBER])
    else $error("latched jabber not returned by read");

  AST_IDENT: assert property (req.rd && (req.idx == psar_pkg::IDX_IDENT_LOW) |=>
    (rd_data_q[9:4] == MODEL_NUM) && (rd_data_q[3:0] == REV_NUM))
    else $error("identifier low word wrong");

  AST_STRAP: assert property ($rose(strap_done_q) |->
    (advert_q[psar_pkg::AD_TX_FD] == $past(strap_sync)) &&
    (advert_q[psar_pkg::AD_10_FD] == $past(strap_sync)) &&
    (advert_q[psar_pkg::AD_10_HD] == $past(strap_sync)))
    else $error("strap not loaded into advertisement");

  AST_ADVERT_WR: assert property (wr_advert && strap_done_q |=>
    (advert_q == ($past(req.wdata) & psar_pkg::ADVERT_WMASK)) &&
    !advert_q[psar_pkg::AD_ACK])
    else $error("advertisement write wrong");

  AST_PARTNER_ACK: assert property (req.rd && (req.idx == psar_pkg::IDX_PARTNER) |=>
    !rd_data_q[psar_pkg::AD_ACK])
    else $error("partner acknowledge bit set");

  // an event in the read cycle must survive the release
  AST_RFAULT_SET: assert property (cond.remote_fault |=> rfault_q)
    else $error("remote fault event not latched");

  AST_JABBER_SET: assert property (cond.jabber |=> jabber_q)
    else $error("jabber event not latched");

  AST_LINK_RECOVER: assert property (seq_status_rd |=> (link_q == $past(cond.link_up)))
    else $error("link latch did not follow line after read");

  // only a write may move the advertisement once the strap is in
  AST_ADVERT_HOLD: assert property (!wr_advert && strap_done_q |=> $stable(advert_q))
    else $error("advertisement changed without write");

  AST_PARTNER_CAPTURE: assert property (seq_partner_in |=>
    (partner_q == ($past(partner_word) & psar_pkg::PARTNER_MASK)))
    else $error("partner word not captured");

  AST_RD_PULSE: assert property (1'b1 |=> (rd_valid_q == $past(req.rd)))
    else $error("read valid pulse wrong");

  AST_UNMAPPED_ZERO: assert property (
    req.rd && ((req.idx < psar_pkg::IDX_STATUS) || (req.idx > psar_pkg::IDX_PARTNER)) |=>
    (rd_data_q == '0))
    else $error("unmapped index read not zero");

endmodule : psar_regs

// >>> inc/psar_pkg.sv
// shared constants and carrier types for the phy status and autoneg register subset
package psar_pkg;

  // ****************************************
  // register indexes
  // ****************************************
  localparam logic [4:0] IDX_STATUS = 5'h01;
  localparam logic [4:0] IDX_IDENT_HIGH = 5'h02;
  localparam logic [4:0] IDX_IDENT_LOW = 5'h03;
  localparam logic [4:0] IDX_ADVERT = 5'h04;
  localparam logic [4:0] IDX_PARTNER = 5'h05;

  // ****************************************
  // status fields
  // ****************************************
  localparam int ST_T4 = 15;
  localparam int ST_CAP_HI = 14;
  localparam int ST_CAP_LO = 11;
  localparam int ST_AN_DONE = 5;
  localparam int ST_RFAULT = 4;
  localparam int ST_AN_ABLE = 3;
  localparam int ST_LINK = 2;
  localparam int ST_JABBER = 1;
  localparam int ST_EXT_CAP = 0;
  localparam logic [3:0] ST_CAPS = 4'hf;

  // ****************************************
  // advertisement and partner fields
  // ****************************************
  localparam int AD_NEXT_PAGE = 15;
  localparam int AD_ACK = 14;
  localparam int AD_RFAULT = 13;
  localparam int AD_RSVD12 = 12;
  localparam int AD_PAUSE_HI = 11;
  localparam int AD_PAUSE_LO = 10;
  localparam int AD_T4 = 9;
  localparam int AD_TX_FD = 8;
  localparam int AD_TX_HD = 7;
  localparam int AD_10_FD = 6;
  localparam int AD_10_HD = 5;
  localparam int AD_SEL_HI = 4;
  localparam logic [15:0] ADVERT_RESET = 16'h0081;
  localparam logic [15:0] ADVERT_WMASK = 16'hbfff;
  localparam logic [15:0] PARTNER_RESET = 16'h0001;
  localparam logic [15:0] PARTNER_MASK = 16'hafff;
  localparam logic [1:0] PAUSE_NONE = 2'h0;
  localparam logic [1:0] PAUSE_SYM = 2'h1;
  localparam logic [1:0] PAUSE_ASYM = 2'h2;
  localparam logic [1:0] PAUSE_BOTH = 2'h3;

  // ****************************************
  // identity fields and strap timing
  // ****************************************
  localparam int ID_OUI_LSB = 10;
  localparam int ID_MODEL_LSB = 4;
  localparam logic [1:0] STRAP_SETTLE = 2'h2;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [4:0] idx;
    logic [15:0] wdata;
  } psar_req_t;

  typedef struct packed {
    logic link_up;
    logic remote_fault;
    logic jabber;
    logic an_done;
  } psar_cond_t;

endpackage : psar_pkg

// >>> core/psar_sync.sv
// two flip-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/1ps
module psar_sync #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk, // 25 MHz clock
  input wire logic resetn, // async reset, active low
  input wire logic [WIDTH-1:0] async_in, // unsynchronised level
  output logic [WIDTH-1:0] sync_q // synchronised level
);

  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

endmodule : psar_sync

// >>> dv/psar_mgmt_model.sv
// management access model: turns host indexed accesses into register requests
`timescale 1ns/1ps
module psar_mgmt_model (
  input wire logic ref_clk, // 25 MHz clock
  output psar_pkg::psar_req_t req // indexed request to the registers
);
  // ****************************************
  // request driver
  // ****************************************
  initial req = '0;

  // one indexed access per call; idle fields show inverted garbage, not stale values
  task automatic xfer(input logic rd, input logic wr, input logic [4:0] idx,
    input logic [15:0] wd);
    @(posedge ref_clk);
    #1 req = '{rd: rd, wr: wr, idx: idx, wdata: wd};
    @(posedge ref_clk);
    #1 req = '{rd: 1'b0, wr: 1'b0, idx: ~idx, wdata: ~wd};
  endtask : xfer
endmodule : psar_mgmt_model

// >>> dv/testbench.sv
// self-checking bench for the phy status and autoneg register subset
`timescale 1ns/1ps
module testbench;
  logic ref_clk;
  logic resetn;
  psar_pkg::psar_req_t req;
  psar_pkg::psar_cond_t cond;
  logic partner_valid;
  logic [15:0] partner_word;
  logic speed_sel_pin;
  logic [15:0] rd_data_q;
  logic rd_valid_q;
  logic [15:0] advert_q;
  logic [15:0] partner_q;
  logic [15:0] exp_q[$];
  logic [15:0] w;
  int mismatches;
  int compares;

  // ****************************************
  // clock, instances, tasks
  // ****************************************
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  psar_regs dut (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .req(req),
    .cond(cond),
    .partner_valid(partner_valid),
    .partner_word(partner_word),
    .speed_sel_pin(speed_sel_pin),
    .rd_data_q(rd_data_q),
    .rd_valid_q(rd_valid_q),
    .advert_q(advert_q),
    .partner_q(partner_q)
  );

  psar_mgmt_model mac (
    .ref_clk(ref_clk),
    .req(req)
  );

  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  task automatic rd(input logic [4:0] idx, input logic [15:0] exp);
    exp_q.push_back(exp);
    mac.xfer(1'b1, 1'b0, idx, 16'h0000);
  endtask : rd

  task automatic wr(input logic [4:0] idx, input logic [15:0] wd);
    mac.xfer(1'b0, 1'b1, idx, wd);
  endtask : wr

  // bounded wait for every pending read answer
  task automatic drain(input string name);
    for (int k = 0; k < 20 && exp_q.size() > 0; k++) @(posedge ref_clk);
    if (exp_q.size() > 0)
    begin
      mismatches++;
      test_done();
    end
    else
      $display("test %s done", name);
  endtask : drain

  // direct look at a register output that the engine side consumes
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic do_reset(input logic strap);
    resetn = 1'b0;
    speed_sel_pin = strap;
    repeat (4) @(posedge ref_clk);
    #1 resetn = 1'b1;
    repeat (4) @(posedge ref_clk);
  endtask : do_reset

  // sampled mid-cycle so the registered answer has settled
  always @(negedge ref_clk)
    if (rd_valid_q === 1'b1)
    begin
      compares++;
      if (exp_q.size() == 0 || rd_data_q !== exp_q[0])
      begin
        mismatches++;
        $display("[ERR] t=%0t got %h exp %h", $time, rd_data_q,
          exp_q.size() > 0 ? exp_q[0] : 16'hxxxx);
      end
      if (exp_q.size() > 0)
        void'(exp_q.pop_front());
    end

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    cond = 4'h8;
    partner_valid = 1'b0;
    partner_word = 16'h0000;
    void'($urandom(25));
    do_reset(1'b1);
    rd(5'h02, 16'h1234);
    rd(5'h03, {6'h15, 6'h0a, 4'h1});
    rd(5'h04, 16'h01e1);
    chk(advert_q, 16'h01e1);
    rd(5'h05, 16'h0001);
    chk(partner_q, 16'h0001);
    rd(5'h01, 16'h7809);
    rd(5'h01, 16'h780d);
    rd(5'h00, 16'h0000);
    drain("reset values");
    #1 cond = 4'h6;
    @(posedge ref_clk);
    #1 cond = 4'h8;
    repeat (2) @(posedge ref_clk);
    rd(5'h01, 16'h781b);
    rd(5'h01, 16'h780d);
    cond = 4'h9;
    rd(5'h01, 16'h782d);
    drain("status latches");
    for (int p = 0; p < 4; p++)
    begin
      // next page and t4 stay cleared, as software must keep them
      w = (16'($urandom()) & 16'h31ff) | 16'(p << 10);
      wr(5'h04, w | 16'h4000);
      rd(5'h04, w);
      chk(advert_q, w);
      wr(5'h05, w);
      rd(5'h05, 16'h0001);
    end
    wr(5'h02, 16'($urandom()));
    rd(5'h02, 16'h1234);
    wr(5'h01, 16'h0000);
    rd(5'h01, 16'h782d);
    drain("advert writes");
    w = 16'($urandom());
    @(posedge ref_clk);
    #1 partner_valid = 1'b1;
    partner_word = w;
    @(posedge ref_clk);
    #1 partner_valid = 1'b0;
    partner_word = ~w;
    rd(5'h05, w & 16'hafff);
    chk(partner_q, w & 16'hafff);
    drain("partner ability");
    #1 do_reset(1'b0);
    rd(5'h04, 16'h0081);
    chk(advert_q, 16'h0081);
    rd(5'h01, 16'h7829);
    drain("strap low");
    test_done();
  end
endmodule : testbench
